// File: logic/win_pkg.sv
`default_nettype none

package win_pkg;

   // ---------------------------------------------------------------
   // Register map, byte addresses
   // ---------------------------------------------------------------
   localparam logic [7:0]  OFS_CONTROL     = 8'h00;
   localparam logic [7:0]  OFS_PAIR_CFG    = 8'h04;
   localparam logic [7:0]  OFS_CHAN_SEL    = 8'h08;
   localparam logic [7:0]  OFS_LT_LOW      = 8'h0c;
   localparam logic [7:0]  OFS_LT_HIGH     = 8'h10;
   localparam logic [7:0]  OFS_GT_LOW      = 8'h14;
   localparam logic [7:0]  OFS_GT_HIGH     = 8'h18;
   localparam logic [7:0]  OFS_RES_LOW     = 8'h1c;
   localparam logic [7:0]  OFS_RES_HIGH    = 8'h20;
   localparam logic [7:0]  OFS_IRQ_STATUS  = 8'h24;
   localparam logic [7:0]  OFS_IRQ_MASK    = 8'h28;

   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int          CTL_LJST_BIT    = 0;
   localparam int          IRQ_WIN_BIT     = 0;
   localparam int          IRQ_EOC_BIT     = 1;
   localparam int          IRQ_BITS        = 2;

   // ---------------------------------------------------------------
   // Values after reset
   // ---------------------------------------------------------------
   localparam logic [7:0]  RST_LT_LOW      = 8'h00;
   localparam logic [7:0]  RST_LT_HIGH     = 8'h00;
   localparam logic [7:0]  RST_GT_LOW      = 8'hff;
   localparam logic [7:0]  RST_GT_HIGH     = 8'hff;
   localparam logic [7:0]  RST_BYTE        = 8'h00;
   localparam logic [1:0]  RST_IRQ         = 2'h0;

   // ---------------------------------------------------------------
   // Carriers
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [7:0]  paddr;
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [31:0] pwdata;
   } apb_req_t;

   typedef struct packed {
      logic        done;
      logic [11:0] code;
   } conv_word_t;

   typedef enum logic {
      ST_IDLE = 1'b0,
      ST_ACK  = 1'b1
   } apb_state_t;

endpackage

`default_nettype wire

// File: logic/adc_window_comparator.sv
// Implementation choices: the APB slave port and the address map.
`timescale 1ns/1ps
`default_nettype none

module adc_window_comparator (
   input  wire logic                i_mclk,
   input  wire logic                i_rst_n,
   input  wire win_pkg::apb_req_t   i_apb,
   input  wire win_pkg::conv_word_t i_conv,
   output logic [31:0]              o_prdata,
   output logic                     o_pready,
   output logic                     o_pslverr,
   output logic                     o_irq,
   output logic                     o_window_match_flag,
   output logic [2:0]               o_input_channel_select
);
   import win_pkg::*;

   // ---------------------------------------------------------------
   // Functions
   // ---------------------------------------------------------------
   function automatic logic addr_mapped(input logic [7:0] a);
      addr_mapped = (a == OFS_CONTROL)    || (a == OFS_PAIR_CFG)  ||
                    (a == OFS_CHAN_SEL)   || (a == OFS_LT_LOW)    ||
                    (a == OFS_LT_HIGH)    || (a == OFS_GT_LOW)    ||
                    (a == OFS_GT_HIGH)    || (a == OFS_RES_LOW)   ||
                    (a == OFS_RES_HIGH)   || (a == OFS_IRQ_STATUS)||
                    (a == OFS_IRQ_MASK);
   endfunction

   // Strict less-than in the chosen number system
   function automatic logic word_below(input logic [15:0] a,
                                       input logic [15:0] b,
                                       input logic        sgn);
      word_below = sgn ? ($signed(a) < $signed(b)) : (a < b);
   endfunction

   // ---------------------------------------------------------------
   // Storage
   // ---------------------------------------------------------------
   apb_state_t  state;
   logic        left_justify_select;
   logic [7:0]  input_pair_config;
   logic [7:0]  input_channel_select;
   logic [7:0]  less_than_limit_low;
   logic [7:0]  less_than_limit_high;
   logic [7:0]  greater_than_limit_low;
   logic [7:0]  greater_than_limit_high;
   logic [7:0]  result_low_byte;
   logic [7:0]  result_high_byte;
   logic [1:0]  irq_status;
   logic [1:0]  irq_mask;

   logic        wr_fire;
   logic [15:0] lt_word;
   logic [15:0] gt_word;
   logic [15:0] new_word;
   logic        differential;
   logic        inside_mode;
   logic        below_lt;
   logic        above_gt;
   logic        window_hit;
   logic [1:0]  irq_set;
   logic [1:0]  irq_clr;
   logic [1:0]  next_irq_status;
   logic [1:0]  next_irq_mask;
   logic [31:0] next_prdata;

   // ---------------------------------------------------------------
   // APB slave, one wait state
   // ---------------------------------------------------------------
   assign wr_fire = i_apb.psel & i_apb.penable & o_pready & i_apb.pwrite;

   always_comb begin
      next_prdata = 32'h0000_0000;
      unique case (i_apb.paddr)
         OFS_CONTROL:    next_prdata[CTL_LJST_BIT] = left_justify_select;
         OFS_PAIR_CFG:   next_prdata[7:0] = input_pair_config;
         OFS_CHAN_SEL:   next_prdata[7:0] = input_channel_select;
         OFS_LT_LOW:     next_prdata[7:0] = less_than_limit_low;
         OFS_LT_HIGH:    next_prdata[7:0] = less_than_limit_high;
         OFS_GT_LOW:     next_prdata[7:0] = greater_than_limit_low;
         OFS_GT_HIGH:    next_prdata[7:0] = greater_than_limit_high;
         OFS_RES_LOW:    next_prdata[7:0] = result_low_byte;
         OFS_RES_HIGH:   next_prdata[7:0] = result_high_byte;
         OFS_IRQ_STATUS: next_prdata[IRQ_BITS-1:0] = irq_status;
         OFS_IRQ_MASK:   next_prdata[IRQ_BITS-1:0] = irq_mask;
         default:        next_prdata = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state     <= ST_IDLE;
         o_pready  <= 1'b0;
         o_pslverr <= 1'b0;
         o_prdata  <= 32'h0000_0000;
      end else begin
         unique case (state)
            ST_IDLE: begin
               if (i_apb.psel && i_apb.penable) begin
                  state     <= ST_ACK;
                  o_pready  <= 1'b1;
                  o_pslverr <= ~addr_mapped(i_apb.paddr);
                  o_prdata  <= i_apb.pwrite ? 32'h0000_0000 : next_prdata;
               end
            end
            ST_ACK: begin
               state     <= ST_IDLE;
               o_pready  <= 1'b0;
               o_pslverr <= 1'b0;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Configuration and limit registers
   // ---------------------------------------------------------------
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         left_justify_select     <= 1'b0;
         input_pair_config       <= RST_BYTE;
         input_channel_select    <= RST_BYTE;
         less_than_limit_low     <= RST_LT_LOW;
         less_than_limit_high    <= RST_LT_HIGH;
         greater_than_limit_low  <= RST_GT_LOW;
         greater_than_limit_high <= RST_GT_HIGH;
         irq_mask                <= RST_IRQ;
      end else if (wr_fire) begin
         unique case (i_apb.paddr)
            OFS_CONTROL:  left_justify_select <= i_apb.pwdata[CTL_LJST_BIT];
            OFS_PAIR_CFG: input_pair_config   <= i_apb.pwdata[7:0];
            OFS_CHAN_SEL: input_channel_select <= i_apb.pwdata[7:0];
            OFS_LT_LOW:   less_than_limit_low  <= i_apb.pwdata[7:0];
            OFS_LT_HIGH:  less_than_limit_high <= i_apb.pwdata[7:0];
            OFS_GT_LOW:   greater_than_limit_low  <= i_apb.pwdata[7:0];
            OFS_GT_HIGH:  greater_than_limit_high <= i_apb.pwdata[7:0];
            OFS_IRQ_MASK: irq_mask <= i_apb.pwdata[IRQ_BITS-1:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_input_channel_select <= 3'h0;
      end else begin
         o_input_channel_select <= input_channel_select[2:0];
      end
   end

   // ---------------------------------------------------------------
   // Result word formation
   // ---------------------------------------------------------------
   // Limit words, high byte above low
   // Limit concatenation
   assign lt_word = {less_than_limit_high, less_than_limit_low};
   assign gt_word = {greater_than_limit_high, greater_than_limit_low};

   // Each pair of channels shares one pair-config bit
   assign differential = input_pair_config[{1'b0, input_channel_select[2:1]}];

   // Word as the result registers will hold it
   // Justify placement select
   always_comb begin
      if (left_justify_select) begin
         new_word = {i_conv.code, 4'h0};
      end else begin
         new_word = {{4{differential & i_conv.code[11]}}, i_conv.code};
      end
   end

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         result_low_byte  <= RST_BYTE;
         result_high_byte <= RST_BYTE;
      end else if (i_conv.done) begin
         result_low_byte  <= new_word[7:0];
         result_high_byte <= new_word[15:8];
      end
   end

   // ---------------------------------------------------------------
   // Window comparison
   // ---------------------------------------------------------------
   // Limits must share the word's justification; no realignment here
   // Compare as stored
   assign below_lt    = word_below(new_word, lt_word, differential);
   assign above_gt    = word_below(gt_word, new_word, differential);
   assign inside_mode = word_below(gt_word, lt_word, differential);

   always_comb begin
      if (inside_mode) begin
         window_hit = below_lt & above_gt;
      end else begin
         window_hit = below_lt | above_gt;
      end
   end

   // ---------------------------------------------------------------
   // Sticky status and interrupt
   // ---------------------------------------------------------------
   // Evaluate at end of conversion
   assign irq_set[IRQ_WIN_BIT] = i_conv.done & window_hit;
   assign irq_set[IRQ_EOC_BIT] = i_conv.done;
   assign irq_clr = (wr_fire && i_apb.paddr == OFS_IRQ_STATUS)
                    ? i_apb.pwdata[IRQ_BITS-1:0] : 2'h0;
   // New mask counts at once, so the level never lags a mask write
   assign next_irq_mask = (wr_fire && i_apb.paddr == OFS_IRQ_MASK)
                          ? i_apb.pwdata[IRQ_BITS-1:0] : irq_mask;

   // Set beats clear so a same-cycle event is never dropped
   // Sticky match flag
   assign next_irq_status = irq_set | (irq_status & ~irq_clr);

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         irq_status <= RST_IRQ;
      end else begin
         irq_status <= next_irq_status;
      end
   end

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_irq               <= 1'b0;
         o_window_match_flag <= 1'b0;
      end else begin
         o_irq               <= |(next_irq_status & next_irq_mask);
         o_window_match_flag <= next_irq_status[IRQ_WIN_BIT];
      end
   end

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   logic clr_win;
   assign clr_win = irq_clr[IRQ_WIN_BIT];

   sequence eoc_s;
      i_conv.done;
   endsequence

   sequence flag_up_s;
      irq_status[IRQ_WIN_BIT] ##0 o_window_match_flag;
   endsequence

   match_set_a: assert property (
      @(posedge i_mclk) disable iff (!i_rst_n)
      (eoc_s ##0 window_hit) |=> flag_up_s)
      else $error("match flag not set after window hit");

   inside_win_a: assert property (
      @(posedge i_mclk) disable iff (!i_rst_n)
      (eoc_s ##0 (!differential && lt_word > gt_word &&
                  new_word < lt_word && new_word > gt_word))
      |=> flag_up_s)
      else $error("inside window word not flagged");

   outside_win_a: assert property (
      @(posedge i_mclk) disable iff (!i_rst_n)
      (eoc_s ##0 (!differential && lt_word < gt_word && !clr_win &&
                  !irq_status[IRQ_WIN_BIT] &&
                  new_word >= lt_word && new_word <= gt_word))
      |=> !irq_status[IRQ_WIN_BIT])
      else $error("word between limits flagged in outside mode");

   signed_cmp_a: assert property (
      @(posedge i_mclk) disable iff (!i_rst_n)
      (eoc_s ##0 (differential && !left_justify_select &&
                  lt_word == 16'h0100 && gt_word == 16'hffff &&
                  i_conv.code == 12'h000))
      |=> flag_up_s)
      else $error("zero not inside signed window");

   sign_ext_a: assert property (
      @(posedge i_mclk) disable iff (!i_rst_n)
      (eoc_s ##0 (differential && !left_justify_select &&
                  i_conv.code == 12'hfff))
      |=> {result_high_byte, result_low_byte} == 16'hffff)
      else $error("minus one not encoded as all ones");

   left_diff_a: assert property (
      @(posedge i_mclk) disable iff (!i_rst_n)
      (eoc_s ##0 (differential && left_justify_select &&
                  lt_word == 16'h1000 && gt_word == 16'hfff0 &&
                  !irq_status[IRQ_WIN_BIT] && !clr_win &&
                  i_conv.code == 12'h800))
      |=> !irq_status[IRQ_WIN_BIT] ##1 (!irq_status[IRQ_WIN_BIT] ||
          $past(irq_set[IRQ_WIN_BIT])))
      else $error("most negative word flagged in signed window");

   rj_signed_a: assert property (
      @(posedge i_mclk) disable iff (!i_rst_n)
      (eoc_s ##0 (differential && !left_justify_select &&
                  lt_word == 16'hffff && gt_word == 16'h0100 &&
                  i_conv.code == 12'h800))
      |=> flag_up_s)
      else $error("most negative word missed outside signed window");

   left_low_a: assert property (
      @(posedge i_mclk) disable iff (!i_rst_n)
      (eoc_s ##0 left_justify_select)
      |=> result_low_byte[3:0] == 4'h0 &&
          result_high_byte == $past(i_conv.code[11:4]))
      else $error("left justified placement wrong");

   flag_hold_a: assert property (
      @(posedge i_mclk) disable iff (!i_rst_n)
      (irq_status[IRQ_WIN_BIT] && !clr_win)
      |=> irq_status[IRQ_WIN_BIT])
      else $error("match flag dropped without a clear");

   miss_keep_a: assert property (
      @(posedge i_mclk) disable iff (!i_rst_n)
      (eoc_s ##0 (!window_hit && !clr_win))
      |=> irq_status[IRQ_WIN_BIT] == $past(irq_status[IRQ_WIN_BIT]))
      else $error("non matching word changed match flag");

   irq_level_a: assert property (
      @(posedge i_mclk) disable iff (!i_rst_n)
      o_irq == |(irq_status & irq_mask))
      else $error("interrupt not tracking masked status");

endmodule

`default_nettype wire

// File: verification/conv_source.sv
`timescale 1ns/1ps
`default_nettype none

module conv_source (
   input  wire logic              i_mclk,
   output var  win_pkg::conv_word_t o_conv
);
   import win_pkg::*;

   // -------------------------------------------------
   // Converter core delivering finished words
   // -------------------------------------------------
   initial begin
      o_conv = '0;
   end

   // Code line shows inverted junk outside done, never the old word
   task automatic send(input logic [11:0] code, input int gap);
      repeat (gap) @(posedge i_mclk);
      @(posedge i_mclk);
      o_conv <= '{done: 1'b1, code: code};
      @(posedge i_mclk);
      o_conv <= '{done: 1'b0, code: ~code};
   endtask

endmodule

`default_nettype wire

// File: verification/testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
   import win_pkg::*;

   logic        i_mclk;
   logic        i_rst_n;
   apb_req_t    apb;
   conv_word_t  conv;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        irq;
   logic        flag;
   logic [2:0]  chan_out;
   int          err_count;
   int          n_tests;
   logic [1:0]  st;
   logic [1:0]  mask;
   logic [2:0]  chan;
   logic [3:0]  pair;
   logic [15:0] lt;
   logic [15:0] gt;
   logic [11:0] c;
   logic [31:0] r;
   logic        e;
   int          w;

   logic [15:0] lt_tab [7] = '{16'h0200, 16'h0100, 16'h0100, 16'hffff,
                               16'h1000, 16'h2000, 16'hfff0};
   logic [15:0] gt_tab [7] = '{16'h0100, 16'h0200, 16'hffff, 16'h0100,
                               16'hfff0, 16'h1000, 16'h1000};
   bit          sg_tab [7] = '{0, 0, 1, 1, 1, 0, 1};
   bit          lj_tab [7] = '{0, 0, 0, 0, 1, 1, 1};
   logic [11:0] code_tab [9] = '{12'h100, 12'h0ff, 12'h101, 12'h200,
                                 12'h201, 12'hfff, 12'h800, 12'h7ff,
                                 12'h000};

   adc_window_comparator dut (
      .i_mclk                 (i_mclk),
      .i_rst_n                (i_rst_n),
      .i_apb                  (apb),
      .i_conv                 (conv),
      .o_prdata               (prdata),
      .o_pready               (pready),
      .o_pslverr              (pslverr),
      .o_irq                  (irq),
      .o_window_match_flag    (flag),
      .o_input_channel_select (chan_out)
   );

   conv_source src (
      .i_mclk (i_mclk),
      .o_conv (conv)
   );

   always #10 i_mclk = ~i_mclk;

   // -------------------------------------------------
   // Reporting
   // -------------------------------------------------
   task automatic test_done();
      $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, exp, input string what);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   // -------------------------------------------------
   // Bus master
   // -------------------------------------------------
   task automatic xfer(input logic wr, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] rd,
                       output logic er);
      int n;
      @(posedge i_mclk);
      apb <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: wr, pwdata: d};
      @(posedge i_mclk);
      apb.penable <= 1'b1;
      n = 0;
      do begin
         @(posedge i_mclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      er = pslverr;
      apb <= '0;
      if (pready !== 1'b1) begin
         err_count++;
         $display("ERROR %0t bus answer never came", $time);
         test_done();
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] rd;
      logic        er;
      xfer(1'b1, a, d, rd, er);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp,
                         input string what);
      logic [31:0] rd;
      logic        er;
      xfer(1'b0, a, 32'h0, rd, er);
      chk(rd, exp, what);
   endtask

   // -------------------------------------------------
   // Reference model
   // -------------------------------------------------
   function automatic int word_of(logic [11:0] cd, bit lj, bit sg);
      if (lj)
         return {cd, 4'h0};
      if (sg && cd[11])
         return {4'hf, cd};
      return {4'h0, cd};
   endfunction

   function automatic int sx(int v, bit sg);
      return (sg && v >= 32768) ? v - 65536 : v;
   endfunction

   // Reversed limits mean inside window, otherwise outside
   function automatic bit hit(int v, int l, int g, bit sg);
      v = sx(v, sg);
      l = sx(l, sg);
      g = sx(g, sg);
      if (l > g)
         return v < l && v > g;
      return v < l || v > g;
   endfunction

   // -------------------------------------------------
   // Main sequence
   // -------------------------------------------------
   initial begin
      i_mclk = 1'b0;
      i_rst_n = 1'b0;
      apb = '0;
      err_count = 0;
      n_tests = 0;
      void'($urandom(88));
      repeat (20) @(posedge i_mclk);
      i_rst_n <= 1'b1;
      rd_chk(OFS_LT_LOW, 32'h00, "lt low reset");
      rd_chk(OFS_LT_HIGH, 32'h00, "lt high reset");
      rd_chk(OFS_GT_LOW, 32'hff, "gt low reset");
      rd_chk(OFS_GT_HIGH, 32'hff, "gt high reset");
      xfer(1'b0, 8'h3c, 32'h0, r, e);
      chk(e, 1'b1, "unmapped error");
      chk(r, 32'h0, "unmapped data");
      for (int k = 0; k < 7; k++) begin
         lt = lt_tab[k];
         gt = gt_tab[k];
         chan = 3'($urandom);
         pair = 4'($urandom);
         pair[chan[2:1]] = sg_tab[k];
         mask = 2'($urandom);
         wr(OFS_CONTROL, {31'h0, lj_tab[k]});
         wr(OFS_PAIR_CFG, {28'h0, pair});
         wr(OFS_CHAN_SEL, {29'h0, chan});
         // Limits in the justification in force
         wr(OFS_LT_LOW, {24'h0, lt[7:0]});
         wr(OFS_LT_HIGH, {24'h0, lt[15:8]});
         wr(OFS_GT_LOW, {24'h0, gt[7:0]});
         wr(OFS_GT_HIGH, {24'h0, gt[15:8]});
         wr(OFS_IRQ_MASK, {30'h0, mask});
         wr(OFS_IRQ_STATUS, 32'h3);
         st = 2'h0;
         chk(chan_out, chan, "channel out");
         for (int j = 0; j < 12; j++) begin
            c = (j < 9) ? code_tab[j] : 12'($urandom);
            if ($urandom % 2) begin
               // Software clear before looking for the next match
               wr(OFS_IRQ_STATUS, 32'h3);
               st = 2'h0;
            end
            src.send(c, $urandom % 3);
            w = word_of(c, lj_tab[k], sg_tab[k]);
            st = {1'b1, st[0] | hit(w, lt, gt, sg_tab[k])};
            @(posedge i_mclk);
            #1;
            chk(flag, st[0], "match flag");
            chk(irq, |(st & mask), "irq level");
            wr(OFS_RES_LOW, ~w);
            rd_chk(OFS_RES_LOW, w[7:0], "result low");
            rd_chk(OFS_RES_HIGH, w[15:8], "result high");
            rd_chk(OFS_IRQ_STATUS, st, "status");
         end
      end
      test_done();
   end

endmodule

`default_nettype wire
